//--- shared/srxchk_pkg.sv
// Package with register map, field layout and carrier types for the check
package srxchk_pkg;
    // Register offsets (byte addresses on the configuration port)
    localparam logic [11:0] ADDR_CHECK_CONTROL = 12'h032C;
    localparam logic [11:0] ADDR_EXPECTED_LOW = 12'h032D;
    localparam logic [11:0] ADDR_EXPECTED_HIGH = 12'h032E;
    localparam logic [11:0] ADDR_CHECK_RESULT = 12'h032F;
    localparam logic [11:0] ADDR_LANE_INVERT = 12'h0334;
    localparam logic [11:0] ADDR_DEVICE_IDENT = 12'h0400;
    localparam logic [11:0] ADDR_BANK_IDENT = 12'h0401;
    localparam logic [11:0] ADDR_LANE_ZERO_FLAGS = 12'h0402;
    // Control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_CONV_LSB = 2;
    localparam int CTRL_SAMPLE_LSB = 4;
    // Lane-zero flags field positions
    localparam int FLAG_ADJDIR_BIT = 6;
    localparam int FLAG_PHADJ_BIT = 5;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Geometry
    localparam int SAMPLE_WIDTH = 16;
    localparam int NUM_CONVERTERS = 4;
    localparam int NUM_SAMPLES = 16;
    localparam int NUM_LANES = 8;

    // Configuration port write / read request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [11:0] addr;
        logic [7:0] wdata;
    } srx_cfg_req_t;

    // Lane-zero alignment sequence fields, as captured
    typedef struct packed {
        logic [7:0] device_ident;
        logic [7:0] bank_ident;
        logic adjust_direction;
        logic phase_adjust_request;
        logic [4:0] lane_zero_number;
    } srx_ilas_t;
endpackage

//--- rtl/srx_sample_pick.sv
// Selects one sample of one converter from the receiver output frame
`timescale 1ns/1ps
module srx_sample_pick #(
    parameter int SW = 16,
    parameter int NC = 4,
    parameter int NS = 16
) (
    // Receiver output frame
    input wire logic [NC*NS*SW-1:0] frame,
    // Selection
    input wire logic [1:0] conv_sel,
    input wire logic [3:0] samp_sel,
    // Result
    output logic [SW-1:0] sample
);
    // Sample s of converter c sits at index c*NS+s
    always_comb begin
        sample = frame[(int'(conv_sel) * NS + int'(samp_sel)) * SW +: SW];
    end
endmodule // srx_sample_pick

//--- rtl/srx_lane_invert.sv
// Per-lane inversion of deserialized data
`timescale 1ns/1ps
module srx_lane_invert #(
    parameter int NL = 8,
    parameter int LW = 40
) (
    // Deserialized lane data
    input wire logic [NL*LW-1:0] lanes_in,
    // Inversion control, bit n for lane n
    input wire logic [NL-1:0] invert,
    // Corrected lane data
    output logic [NL*LW-1:0] lanes_out
);
    always_comb begin
        for (int n = 0; n < NL; n++) begin
            lanes_out[n*LW +: LW] = lanes_in[n*LW +: LW] ^ {LW{invert[n]}};
        end
    end
endmodule // srx_lane_invert

//--- rtl/srx_check_top.sv
// Sample check, lane inversion and lane-zero alignment capture
`timescale 1ns/1ps
module srx_check_top #(
    parameter int LANE_WIDTH = 40
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Configuration port
    input wire logic CFG_WR_EN,
    input wire logic CFG_RD_EN,
    input wire logic [11:0] CFG_ADDR,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA,
    output logic CFG_RVALID,
    // Deserialized lanes
    input wire logic [srxchk_pkg::NUM_LANES*LANE_WIDTH-1:0] LANE_DATA_IN,
    output logic [srxchk_pkg::NUM_LANES*LANE_WIDTH-1:0] LANE_DATA_OUT,
    // Receiver output samples
    input wire logic FRAME_VALID,
    input wire logic [srxchk_pkg::NUM_CONVERTERS*srxchk_pkg::NUM_SAMPLES*
        srxchk_pkg::SAMPLE_WIDTH-1:0] FRAME_DATA,
    // Lane-zero alignment sequence fields
    input wire logic ILAS_VALID,
    input wire srxchk_pkg::srx_ilas_t ILAS_FIELDS,
    // Status
    output logic CHECK_MISMATCH
);
    srxchk_pkg::srx_cfg_req_t req;
    logic [7:0] check_control;
    logic [7:0] expected_low_byte;
    logic [7:0] expected_high_byte;
    logic [7:0] lane_invert_bits;
    logic check_mismatch_flag;
    srxchk_pkg::srx_ilas_t ilas;
    logic [1:0] check_converter_index;
    logic [3:0] check_sample_index;
    logic check_enable;
    logic check_result_clear;
    logic [srxchk_pkg::SAMPLE_WIDTH-1:0] picked;
    logic [srxchk_pkg::SAMPLE_WIDTH-1:0] expected;
    logic [srxchk_pkg::NUM_LANES*LANE_WIDTH-1:0] next_lanes;
    logic [7:0] next_rdata;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction

    assign req = '{wr_en: CFG_WR_EN, rd_en: CFG_RD_EN, addr: CFG_ADDR,
                   wdata: CFG_WDATA};
    assign check_sample_index =
        check_control[srxchk_pkg::CTRL_SAMPLE_LSB +: 4];
    assign check_converter_index =
        check_control[srxchk_pkg::CTRL_CONV_LSB +: 2];
    assign check_enable = check_control[srxchk_pkg::CTRL_ENABLE_BIT];
    assign check_result_clear = check_control[srxchk_pkg::CTRL_CLEAR_BIT];
    assign expected = {expected_high_byte, expected_low_byte};

    // Control register write
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            check_control <= srxchk_pkg::RESET_BYTE;
        end else if (req.wr_en && hit(req.addr,
                srxchk_pkg::ADDR_CHECK_CONTROL)) begin
            check_control <= req.wdata;
        end
    end

    // Reference sample bytes
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            expected_low_byte <= srxchk_pkg::RESET_BYTE;
            expected_high_byte <= srxchk_pkg::RESET_BYTE;
        end else if (req.wr_en) begin
            if (hit(req.addr, srxchk_pkg::ADDR_EXPECTED_LOW)) begin
                expected_low_byte <= req.wdata;
            end
            if (hit(req.addr, srxchk_pkg::ADDR_EXPECTED_HIGH)) begin
                expected_high_byte <= req.wdata;
            end
        end
    end

    // Lane inversion control
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            lane_invert_bits <= srxchk_pkg::RESET_BYTE;
        end else if (req.wr_en && hit(req.addr,
                srxchk_pkg::ADDR_LANE_INVERT)) begin
            lane_invert_bits <= req.wdata;
        end
    end

    srx_lane_invert #(
        .NL(srxchk_pkg::NUM_LANES),
        .LW(LANE_WIDTH)
    ) u_invert (
        .lanes_in(LANE_DATA_IN),
        .invert(lane_invert_bits),
        .lanes_out(next_lanes)
    );

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            LANE_DATA_OUT <= '0;
        end else begin
            LANE_DATA_OUT <= next_lanes;
        end
    end

    srx_sample_pick #(
        .SW(srxchk_pkg::SAMPLE_WIDTH),
        .NC(srxchk_pkg::NUM_CONVERTERS),
        .NS(srxchk_pkg::NUM_SAMPLES)
    ) u_pick (
        .frame(FRAME_DATA),
        .conv_sel(check_converter_index),
        .samp_sel(check_sample_index),
        .sample(picked)
    );

    // Sticky mismatch flag; clear control dominates while held at one
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            check_mismatch_flag <= 1'b0;
        end else if (check_result_clear) begin
            check_mismatch_flag <= 1'b0;
        end else if (check_enable && FRAME_VALID) begin
            if (picked != expected) begin
                check_mismatch_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CHECK_MISMATCH <= 1'b0;
        end else begin
            CHECK_MISMATCH <= check_mismatch_flag;
        end
    end

    // Capture of lane-zero alignment fields
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ilas <= '0;
        end else if (ILAS_VALID) begin
            ilas <= ILAS_FIELDS;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = srxchk_pkg::RESET_BYTE;
        case (req.addr)
            srxchk_pkg::ADDR_CHECK_CONTROL: next_rdata = check_control;
            srxchk_pkg::ADDR_EXPECTED_LOW: next_rdata = expected_low_byte;
            srxchk_pkg::ADDR_EXPECTED_HIGH: next_rdata = expected_high_byte;
            srxchk_pkg::ADDR_CHECK_RESULT: begin
                next_rdata = {7'h00, check_mismatch_flag};
            end
            srxchk_pkg::ADDR_LANE_INVERT: next_rdata = lane_invert_bits;
            srxchk_pkg::ADDR_DEVICE_IDENT: begin
                next_rdata = ilas.device_ident;
            end
            srxchk_pkg::ADDR_BANK_IDENT: begin
                next_rdata = ilas.bank_ident;
            end
            srxchk_pkg::ADDR_LANE_ZERO_FLAGS: begin
                next_rdata = srxchk_pkg::RESET_BYTE;
                next_rdata[srxchk_pkg::FLAG_ADJDIR_BIT] =
                    ilas.adjust_direction;
                next_rdata[srxchk_pkg::FLAG_PHADJ_BIT] =
                    ilas.phase_adjust_request;
                next_rdata[4:0] = ilas.lane_zero_number;
            end
            default: next_rdata = srxchk_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CFG_RDATA <= srxchk_pkg::RESET_BYTE;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RVALID <= req.rd_en;
            if (req.rd_en) begin
                CFG_RDATA <= next_rdata;
            end
        end
    end
endmodule // srx_check_top

//--- dv/srx_check_sva.sv
// Assertions on the sample check block ports
`timescale 1ns/1ps
module srx_check_sva #(
    parameter int LW = 40
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Configuration port
    input wire logic CFG_WR_EN,
    input wire logic CFG_RD_EN,
    input wire logic [11:0] CFG_ADDR,
    input wire logic [7:0] CFG_WDATA,
    input wire logic [7:0] CFG_RDATA,
    input wire logic CFG_RVALID,
    // Data paths and status
    input wire logic [8*LW-1:0] LANE_DATA_IN,
    input wire logic [8*LW-1:0] LANE_DATA_OUT,
    input wire logic FRAME_VALID,
    input wire logic [1023:0] FRAME_DATA,
    input wire logic CHECK_MISMATCH
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    logic [7:0] ctl;
    logic [7:0] inv;
    logic [15:0] ref_s;
    logic [15:0] pick;
    logic [8*LW-1:0] exp_out;
    assign pick = FRAME_DATA[{ctl[3:2], ctl[7:4]}*16 +: 16];
    // Mirror of the written control, reference and inversion bytes
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ctl <= 8'h00;
            inv <= 8'h00;
            ref_s <= 16'h0000;
        end else if (CFG_WR_EN) begin
            if (CFG_ADDR == 12'h032C) ctl <= CFG_WDATA;
            if (CFG_ADDR == 12'h032D) ref_s[7:0] <= CFG_WDATA;
            if (CFG_ADDR == 12'h032E) ref_s[15:8] <= CFG_WDATA;
            if (CFG_ADDR == 12'h0334) inv <= CFG_WDATA;
        end
    end
    // Expected lane output one cycle on
    always_ff @(posedge CORE_CLK) begin
        for (int n = 0; n < 8; n++) begin
            exp_out[n*LW +: LW] <= LANE_DATA_IN[n*LW +: LW] ^ {LW{inv[n]}};
        end
    end
    property p_rv;
        !$past(SYS_RST) |-> CFG_RVALID == $past(CFG_RD_EN);
    endproperty
    a_rv: assert property (p_rv) else $error("read valid timing");
    property p_inv;
        !$past(SYS_RST) |-> LANE_DATA_OUT == exp_out;
    endproperty
    a_inv: assert property (p_inv) else $error("lane inversion");
    property p_set;
        ctl[0] && !ctl[1] && FRAME_VALID && pick != ref_s |-> ##2 CHECK_MISMATCH;
    endproperty
    a_set: assert property (p_set) else $error("missed mismatch");
    property p_cause;
        $rose(CHECK_MISMATCH) |->
            $past(ctl[0] && !ctl[1] && FRAME_VALID && pick != ref_s, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("false fail");
    property p_hold;
        CHECK_MISMATCH && !$past(ctl[1]) |=> CHECK_MISMATCH;
    endproperty
    a_hold: assert property (p_hold) else $error("fail not held");
    property p_clr;
        ctl[1] |-> ##2 !CHECK_MISMATCH;
    endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_res;
        CFG_RD_EN && CFG_ADDR == 12'h032F |=> CFG_RDATA[7:1] == 7'h00;
    endproperty
    a_res: assert property (p_res) else $error("result upper bits");
    property p_lz7;
        CFG_RD_EN && CFG_ADDR == 12'h0402 |=> !CFG_RDATA[7];
    endproperty
    a_lz7: assert property (p_lz7) else $error("flags bit 7");
endmodule // srx_check_sva

//--- dv/srx_tx_model.sv
// Transmitter stand-in driving frames and lane-zero alignment fields
`timescale 1ns/1ps
module srx_tx_model (
    // Clock and commands
    input wire logic clk,
    input wire logic fire,
    input wire logic [5:0] pos,
    input wire logic [15:0] val,
    input wire logic ilas_go,
    input wire srxchk_pkg::srx_ilas_t ilas_in,
    // Link side
    output logic frame_valid,
    output logic [1023:0] frame_data,
    output logic ilas_valid,
    output srxchk_pkg::srx_ilas_t ilas_fields
);
    // Other slots carry the inverse value; idle data keeps toggling
    always_ff @(posedge clk) begin
        frame_valid <= fire;
        frame_data <= fire ? {64{~val}} : ~frame_data;
        if (fire) frame_data[pos*16 +: 16] <= val;
    end
    // Alignment fields in protocol order, toggling while idle
    always_ff @(posedge clk) begin
        ilas_valid <= ilas_go;
        ilas_fields <= ilas_go ? ilas_in : ~ilas_fields;
    end
endmodule // srx_tx_model

//--- dv/tb.sv
// Self-checking bench for the sample check block
`timescale 1ns/1ps
module tb;
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic wr = 1'b0, rdn = 1'b0, fire = 1'b0, go = 1'b0;
    logic fv, iv, mm, rv;
    logic [11:0] addr = 12'h0000;
    logic [7:0] wd = 8'h00, rdat;
    logic [5:0] pos = 6'h00;
    logic [15:0] val = 16'h0000;
    logic [319:0] lin = '0, lout;
    logic [1023:0] fd;
    srxchk_pkg::srx_ilas_t il_in = '0, il;
    int err_total = 0, total_checks = 0;
    logic [11:0] regs [8] = '{12'h032D, 12'h032E, 12'h0334, 12'h032F,
        12'h0400, 12'h0401, 12'h0402, 12'h0333};
    always #10 CORE_CLK = ~CORE_CLK;
    srx_check_top srx_check_top_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
        .CFG_WR_EN(wr), .CFG_RD_EN(rdn), .CFG_ADDR(addr), .CFG_WDATA(wd),
        .CFG_RDATA(rdat), .CFG_RVALID(rv), .LANE_DATA_IN(lin),
        .LANE_DATA_OUT(lout), .FRAME_VALID(fv), .FRAME_DATA(fd),
        .ILAS_VALID(iv), .ILAS_FIELDS(il), .CHECK_MISMATCH(mm));
    srx_tx_model srx_tx_model_i (.clk(CORE_CLK), .fire(fire), .pos(pos),
        .val(val), .ilas_go(go), .ilas_in(il_in), .frame_valid(fv),
        .frame_data(fd), .ilas_valid(iv), .ilas_fields(il));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkl(input logic [319:0] got, input logic [319:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr8(input logic [11:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge CORE_CLK);
        wr <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        rdn <= 1'b1;
        addr <= a;
        @(posedge CORE_CLK);
        rdn <= 1'b0;
        @(negedge CORE_CLK);
        chk8(rdat, e);
        chk8({7'h00, rv}, 8'h01);
        @(posedge CORE_CLK);
    endtask
    task automatic send(input logic [5:0] p, input logic [15:0] v);
        fire <= 1'b1;
        pos <= p;
        val <= v;
        @(posedge CORE_CLK);
        fire <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic t_regs();
        foreach (regs[i]) rdc(regs[i], 8'h00);
        foreach (regs[i]) wr8(regs[i], 8'hA5);
        foreach (regs[i]) rdc(regs[i], i < 3 ? 8'hA5 : 8'h00);
    endtask
    task automatic t_check();
        logic [15:0] r;
        logic [7:0] k;
        logic [5:0] p;
        for (int c = 0; c < 4; c++) begin
            p = {c[1:0], 4'(15 - 5 * c)};
            r = {8'hB0 | 8'(c), 8'h3C};
            k = {p[3:0], p[5:4], 2'b01};
            wr8(12'h032D, r[7:0]);
            wr8(12'h032E, r[15:8]);
            wr8(12'h032C, k);
            send(p, r);
            rdc(12'h032F, 8'h00);
            send(p, r ^ (16'h0001 << (5 * c)));
            rdc(12'h032F, 8'h01);
            send(p, r);
            rdc(12'h032F, 8'h01);
            chk8({7'h00, mm}, 8'h01);
            wr8(12'h032C, k ^ 8'h03);
            rdc(12'h032F, 8'h00);
            wr8(12'h032C, k ^ 8'h01);
            send(p, ~r);
            rdc(12'h032F, 8'h00);
        end
    endtask
    task automatic t_invert();
        logic [319:0] e;
        e = {8{40'h12_3456_789A}};
        wr8(12'h0334, 8'h03);
        lin <= e;
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        e[79:0] = ~e[79:0];
        chkl(lout, e);
        @(posedge CORE_CLK);
    endtask
    task automatic t_ilas(input logic [22:0] f, input logic [7:0] flags);
        il_in <= f;
        go <= 1'b1;
        @(posedge CORE_CLK);
        go <= 1'b0;
        @(posedge CORE_CLK);
        rdc(12'h0400, f[22:15]);
        rdc(12'h0401, f[14:7]);
        rdc(12'h0402, flags);
    endtask
    task automatic close_out();
        $display("Checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        t_regs();
        t_check();
        t_invert();
        t_ilas({8'h5A, 8'hC3, 2'b10, 5'h15}, 8'h55);
        t_ilas({8'hA5, 8'h3C, 2'b01, 5'h0A}, 8'h2A);
        close_out();
    end
    initial begin
        repeat (3000) @(posedge CORE_CLK);
        err_total++;
        close_out();
    end
endmodule // tb
bind srx_check_top srx_check_sva #(.LW(LANE_WIDTH)) srx_check_sva_i (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CFG_WR_EN(CFG_WR_EN),
    .CFG_RD_EN(CFG_RD_EN), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
    .LANE_DATA_IN(LANE_DATA_IN), .LANE_DATA_OUT(LANE_DATA_OUT),
    .FRAME_VALID(FRAME_VALID), .FRAME_DATA(FRAME_DATA),
    .CHECK_MISMATCH(CHECK_MISMATCH));
